// >>> pkg/line_fail_pkg.sv
// line_fail_pkg: constants, register map, state codes and carrier
// structs for the line failure and state monitor.
// assumes a single 10 MHz system clock and a 1 ms time base tick.
package line_fail_pkg;

    // ---------------------------------------------------------------
    // clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;
    localparam int TICK_PERIOD_MS = 1;

    // ---------------------------------------------------------------
    // declare and clear windows, nominal values in ms
    // ---------------------------------------------------------------
    localparam int FAIL_DECLARE_MS = 2500;
    localparam int FAIL_CLEAR_MS = 10000;
    localparam int PERSIST_MS = 2500;
    localparam int HIGH_ERR_MS = 30000;
    localparam int PEER_RETURN_MS = 6000;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] FAIL_DECLARE_TICKS = CNT_W'(FAIL_DECLARE_MS / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] FAIL_CLEAR_TICKS = CNT_W'(FAIL_CLEAR_MS / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] PERSIST_TICKS = CNT_W'(PERSIST_MS / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] HIGH_ERR_TICKS = CNT_W'(HIGH_ERR_MS / TICK_PERIOD_MS);
    localparam logic [CNT_W-1:0] PEER_RETURN_TICKS = CNT_W'(PEER_RETURN_MS / TICK_PERIOD_MS);

    // ---------------------------------------------------------------
    // register map (byte addresses) and fields
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'hc;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h7;
    localparam int CMD_IDLE_BIT = 0;
    localparam int CMD_LISTEN_BIT = 1;
    localparam int STATUS_PEER_LATE_BIT = 7;

    // ---------------------------------------------------------------
    // central transceiver states, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_SELFTEST     = 10'h001,
        ST_UNIT_FAIL    = 10'h002,
        ST_IDLE         = 10'h004,
        ST_QUIET_LISTEN = 10'h008,
        ST_INIT_HS      = 10'h010,
        ST_INIT_TRAIN   = 10'h020,
        ST_INIT_DIAG    = 10'h040,
        ST_DATA_MODE    = 10'h080,
        ST_RESYNC       = 10'h100,
        ST_RETRAIN      = 10'h200
    } state_t;

    // ---------------------------------------------------------------
    // carrier structs
    // ---------------------------------------------------------------
    typedef struct packed {
        logic diag_mode;
        logic short_init_en;
        logic retrain_en;
        logic resync_en;
    } ctrl_t;

    typedef struct packed {
        logic carrier_absent;
        logic bad_frame_defect;
        logic margin_deficit_ne;
        logic margin_deficit_fe;
    } defect_t;

    typedef struct packed {
        logic resync_needed_event;
        logic retrain_needed_event;
        logic full_reinit_event;
        logic short_reinit_event;
    } event_t;

    typedef struct packed {
        logic carrier_absent_fail;
        logic framing_gone_fail;
        logic carrier_absent_persist;
        logic framing_gone_persist;
    } failure_t;

    typedef struct packed {
        logic selftest_pass;
        logic selftest_fail;
        logic tone_request;
        logic hs_silent;
        logic hs_done;
        logic init_pass;
        logic init_fail;
        logic diag_done;
        logic resync_pass;
        logic retrain_pass;
    } seq_t;

endpackage

// >>> verilog/line_failure_state_monitor.sv
// line_failure_state_monitor: integrates line defects into failures and
// persistent failures, raises re-sync/re-init events and runs the
// central transceiver state machine; registers over avalon-mm.
// assumes defect, request and sequence inputs are synchronous to mclk_in.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps

module line_failure_state_monitor
    import line_fail_pkg::*;
#(
    parameter logic [TICK_W-1:0] TICK_CYCLES = TICK_W'(TICK_CYCLES_DEF)
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire defect_t defects_in,
    input wire event_t algo_req_in,
    input wire seq_t seq_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output state_t state_out,
    output failure_t failures_out,
    output event_t events_out,
    output logic bad_frame_forced_out,
    output logic tx_on_out,
    output logic rx_on_out
);

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        state_t fsm;
        ctrl_t ctrl;
        logic [TICK_W-1:0] tick_cnt;
        logic [CNT_W-1:0] los_on;
        logic [CNT_W-1:0] los_off;
        logic [CNT_W-1:0] lof_on;
        logic [CNT_W-1:0] lof_off;
        logic [CNT_W-1:0] plos_cnt;
        logic [CNT_W-1:0] plof_cnt;
        logic [CNT_W-1:0] lom_cnt;
        logic [CNT_W-1:0] peer_cnt;
        failure_t fail;
        event_t evt;
        logic awaiting_peer;
        logic peer_late;
        logic sef_forced;
        logic tx_on;
        logic rx_on;
        logic waitreq;
        logic [31:0] rdata;
    } mon_state_t;

    mon_state_t st_r;
    mon_state_t st_nxt;

    // status word layout
    localparam int STAT_FAIL_MSB = 3;
    localparam int STAT_SEF_BIT = 4;
    localparam int STAT_AWAIT_BIT = 5;
    localparam int STAT_CA_BIT = 6;
    localparam int STATE_MSB = 9;

    // saturating window counter, restarts whenever its condition drops
    // saturation keeps a long defect from wrapping
    function automatic logic [CNT_W-1:0] run_cnt(input logic [CNT_W-1:0] c,
                                                 input logic cond,
                                                 input logic tick);
        logic [CNT_W-1:0] r;
        r = c;
        if (!cond) begin
            r = '0;
        end else if (tick && (c != '1)) begin
            r = c + 1'b1;
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic tick;
    logic sef_eff;
    logic ca;
    logic lof_crit;
    logic los_declare;
    logic los_clear;
    logic lof_declare;
    logic lof_clear;
    logic persistent;
    logic high_err_pulse;
    logic in_data;
    logic e_resync;
    logic e_retrain;
    logic e_full;
    logic e_short;
    logic req;
    logic wr_go;
    logic cmd_idle;
    logic cmd_listen;
    logic peer_clr;
    logic dropped;
    logic [31:0] rd_mux;

    always_comb begin
        st_nxt = st_r;

        // fixed 1 ms time base for every window
        // a divider enable keeps one clock domain
        tick = (st_r.tick_cnt == TICK_CYCLES - 1'b1);
        st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 1'b1;

        // own forced bad-frame defect in resync and retrain counts too
        // so a failed resync ends on persistence
        ca = defects_in.carrier_absent;
        sef_eff = defects_in.bad_frame_defect | st_r.sef_forced;

        st_nxt.los_on = run_cnt(st_r.los_on, ca, tick);
        st_nxt.los_off = run_cnt(st_r.los_off, !ca, tick);
        st_nxt.lof_on = run_cnt(st_r.lof_on, sef_eff, tick);
        st_nxt.lof_off = run_cnt(st_r.lof_off, !sef_eff, tick);

        // carrier-absent failure
        // a full window declares even if the defect just fell
        lof_crit = (st_r.lof_on >= FAIL_DECLARE_TICKS);
        los_declare = !st_r.fail.carrier_absent_fail &&
                      ((st_r.los_on >= FAIL_DECLARE_TICKS) ||
                       (ca && lof_crit));
        los_clear = st_r.fail.carrier_absent_fail &&
                    (st_r.los_off >= FAIL_CLEAR_TICKS);

        // framing-gone failure, blocked by any carrier-absent condition
        // the clear term wins over a declare
        lof_declare = !st_r.fail.framing_gone_fail && lof_crit && !ca &&
                      !st_r.fail.carrier_absent_fail;
        lof_clear = st_r.fail.framing_gone_fail &&
                    (los_declare || (st_r.lof_off >= FAIL_CLEAR_TICKS));

        st_nxt.fail.carrier_absent_fail =
            los_declare | (st_r.fail.carrier_absent_fail & !los_clear);
        st_nxt.fail.framing_gone_fail =
            !lof_clear & (st_r.fail.framing_gone_fail | lof_declare);

        // persistence, held only while the base failure holds
        // the extra window lets the peer see the bits
        st_nxt.plos_cnt = run_cnt(st_r.plos_cnt, st_r.fail.carrier_absent_fail & ca, tick);
        st_nxt.plof_cnt = run_cnt(st_r.plof_cnt,
                                  st_r.fail.framing_gone_fail & sef_eff, tick);
        st_nxt.fail.carrier_absent_persist = st_nxt.fail.carrier_absent_fail &
            (st_r.fail.carrier_absent_persist | (st_r.plos_cnt >= PERSIST_TICKS));
        st_nxt.fail.framing_gone_persist = st_nxt.fail.framing_gone_fail &
            (st_r.fail.framing_gone_persist | (st_r.plof_cnt >= PERSIST_TICKS));
        persistent = st_r.fail.carrier_absent_persist | st_r.fail.framing_gone_persist;

        // margin deficit persistence as a high-error-ratio source
        // a saturated counter raises no repeats;
        // a crossing outside data mode is lost
        st_nxt.lom_cnt = run_cnt(st_r.lom_cnt,
            defects_in.margin_deficit_ne | defects_in.margin_deficit_fe, tick);
        high_err_pulse = (st_nxt.lom_cnt >= HIGH_ERR_TICKS) &&
                         (st_r.lom_cnt < HIGH_ERR_TICKS);

        // detector events only mean something in data mode
        // dropped outside it, never queued
        in_data = (st_r.fsm == ST_DATA_MODE);
        e_resync = in_data & algo_req_in.resync_needed_event;
        e_retrain = in_data & (algo_req_in.retrain_needed_event |
                               high_err_pulse);
        e_full = in_data & algo_req_in.full_reinit_event;
        e_short = in_data & algo_req_in.short_reinit_event;
        st_nxt.evt.resync_needed_event = e_resync;
        st_nxt.evt.retrain_needed_event = e_retrain;
        st_nxt.evt.full_reinit_event = e_full;
        st_nxt.evt.short_reinit_event = e_short;

        // bus: an access completes in the cycle waitrequest is low
        // one wait state always, for registered read data
        req = avs_read_in | avs_write_in;
        st_nxt.waitreq = !(st_r.waitreq && req);
        wr_go = !st_r.waitreq && avs_write_in && avs_byteenable_in[0];
        cmd_idle = wr_go && (avs_address_in == REG_CMD) &&
                   avs_writedata_in[CMD_IDLE_BIT];
        cmd_listen = wr_go && (avs_address_in == REG_CMD) &&
                     avs_writedata_in[CMD_LISTEN_BIT];
        peer_clr = wr_go && (avs_address_in == REG_STATUS) &&
                   avs_writedata_in[STATUS_PEER_LATE_BIT];
        if (wr_go && (avs_address_in == REG_CTRL)) begin
            st_nxt.ctrl = avs_writedata_in[CTRL_W-1:0];
        end

        // central transceiver state machine
        // unknown codes restart at selftest
        unique case (st_r.fsm)
            ST_SELFTEST: begin
                if (seq_in.selftest_fail) begin
                    st_nxt.fsm = ST_UNIT_FAIL;
                end else if (seq_in.selftest_pass) begin
                    st_nxt.fsm = ST_IDLE;
                end
            end
            ST_UNIT_FAIL: begin
                // only a reset leaves a failed unit
                st_nxt.fsm = ST_UNIT_FAIL;
            end
            ST_IDLE: begin
                if (cmd_listen) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end
            end
            ST_QUIET_LISTEN: begin
                if (seq_in.tone_request) begin
                    st_nxt.fsm = ST_INIT_HS;
                end
            end
            ST_INIT_HS: begin
                if (seq_in.hs_silent) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end else if (seq_in.hs_done) begin
                    st_nxt.fsm = st_r.ctrl.diag_mode ? ST_INIT_DIAG : ST_INIT_TRAIN;
                end
            end
            ST_INIT_TRAIN: begin
                if (seq_in.init_fail) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end else if (seq_in.init_pass) begin
                    st_nxt.fsm = ST_DATA_MODE;
                end
            end
            ST_INIT_DIAG: begin
                if (seq_in.diag_done) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end
            end
            ST_DATA_MODE: begin
                // persistent failure outranks the detector events
                if (persistent || e_full) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end else if (e_short) begin
                    st_nxt.fsm = st_r.ctrl.short_init_en ? ST_INIT_TRAIN
                                                         : ST_QUIET_LISTEN;
                end else if (e_resync) begin
                    st_nxt.fsm = st_r.ctrl.resync_en ? ST_RESYNC
                                                     : ST_QUIET_LISTEN;
                end else if (e_retrain) begin
                    st_nxt.fsm = st_r.ctrl.retrain_en ? ST_RETRAIN
                                                      : ST_QUIET_LISTEN;
                end
            end
            ST_RESYNC: begin
                // failed attempt just waits for the persistent failure
                if (persistent) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end else if (seq_in.resync_pass) begin
                    st_nxt.fsm = ST_DATA_MODE;
                end
            end
            ST_RETRAIN: begin
                if (persistent) begin
                    st_nxt.fsm = ST_QUIET_LISTEN;
                end else if (seq_in.retrain_pass) begin
                    st_nxt.fsm = ST_DATA_MODE;
                end
            end
            default: begin
                st_nxt.fsm = ST_SELFTEST;
            end
        endcase

        // host idle command wins everywhere except selftest and unit fail
        // selftest and unit fail ignore the host commands
        if (cmd_idle && (st_r.fsm != ST_SELFTEST) && (st_r.fsm != ST_UNIT_FAIL)) begin
            st_nxt.fsm = ST_IDLE;
        end

        // forced bad-frame defect tracks resync and retrain
        st_nxt.sef_forced = (st_nxt.fsm == ST_RESYNC) || (st_nxt.fsm == ST_RETRAIN);

        // line drivers; resync and retrain keep the data signal on
        // idle and quiet listen keep the line silent
        st_nxt.tx_on = (st_nxt.fsm == ST_INIT_HS) || (st_nxt.fsm == ST_INIT_TRAIN) ||
                       (st_nxt.fsm == ST_INIT_DIAG) || (st_nxt.fsm == ST_DATA_MODE) ||
                       st_nxt.sef_forced;
        st_nxt.rx_on = st_nxt.tx_on || (st_nxt.fsm == ST_QUIET_LISTEN);

        // peer return watch after a drop from data signal
        // only a drop from a live signal arms the watch
        dropped = (in_data || st_r.sef_forced) && (st_nxt.fsm == ST_QUIET_LISTEN);
        st_nxt.awaiting_peer = dropped ||
                               (st_r.awaiting_peer && (st_nxt.fsm == ST_QUIET_LISTEN));
        st_nxt.peer_cnt = run_cnt(st_r.peer_cnt, st_r.awaiting_peer, tick);
        // set wins over a software clear in the same cycle
        // clears only by a one written to its status bit
        st_nxt.peer_late = (st_r.awaiting_peer && (st_r.peer_cnt >= PEER_RETURN_TICKS)) ||
                           (st_r.peer_late && !peer_clr);

        // read data, captured the cycle before waitrequest drops
        // address holds through the wait cycle
        rd_mux = '0;
        unique case (avs_address_in)
            REG_CTRL: rd_mux[CTRL_W-1:0] = st_r.ctrl;
            REG_STATUS: begin
                rd_mux[STAT_FAIL_MSB:0] = st_r.fail;
                rd_mux[STAT_SEF_BIT] = sef_eff;
                rd_mux[STAT_AWAIT_BIT] = st_r.awaiting_peer;
                rd_mux[STAT_CA_BIT] = ca;
                rd_mux[STATUS_PEER_LATE_BIT] = st_r.peer_late;
            end
            REG_STATE: rd_mux[STATE_MSB:0] = st_r.fsm;
            default: rd_mux = '0;
        endcase
        if (st_r.waitreq && avs_read_in) begin
            st_nxt.rdata = rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset loads constants only
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
            st_r.fsm <= ST_SELFTEST;
            st_r.ctrl <= CTRL_RESET;
            st_r.waitreq <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs, straight from the state register
    // ---------------------------------------------------------------
    // no logic after the registers
    assign avs_readdata_out = st_r.rdata;
    assign avs_waitrequest_out = st_r.waitreq;
    assign state_out = st_r.fsm;
    assign failures_out = st_r.fail;   // indicator bits toward the peer
    assign events_out = st_r.evt;
    assign bad_frame_forced_out = st_r.sef_forced;
    assign tx_on_out = st_r.tx_on;
    assign rx_on_out = st_r.rx_on;

endmodule

// >>> sim/line_peer_model.sv
// line_peer_model: behavioural far-end transceiver for the monitor bench.
// assumes state_in comes straight from the monitor and all inputs sit on mclk_in.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// peer line end
// ---------------------------------------------------------------
module line_peer_model
    import line_fail_pkg::*;
#(
    parameter int TONE_DELAY = 200
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire state_t state_in,
    input wire logic cut_in,
    input wire logic bad_in,
    output defect_t defects_out,
    output logic tone_out
);
    int wait_r;

    // tone request a fixed time after the far end falls quiet
    // a cut line silences the peer too, so no tones while cut
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wait_r <= 0;
            tone_out <= 1'b0;
        end else begin
            wait_r <= (state_in == ST_QUIET_LISTEN && !cut_in) ? wait_r + 1 : 0;
            tone_out <= (wait_r == TONE_DELAY);
        end
    end

    // margin deficit never raised by this peer
    assign defects_out = '{cut_in, bad_in, 1'b0, 1'b0};
endmodule

// >>> sim/line_monitor_props.sv
// line_monitor_props: concurrent checks on the monitor's ports.
// assumes a bind into line_failure_state_monitor, one clock domain.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module line_monitor_props
    import line_fail_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire defect_t defects_in,
    input wire event_t algo_req_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire state_t state_out,
    input wire failure_t failures_out,
    input wire event_t events_out,
    input wire logic bad_frame_forced_out,
    input wire logic tx_on_out,
    input wire logic rx_on_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    // one wait cycle, then the slave is idle again
    sequence s_one_wait;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    chk_bus_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> s_one_wait) else $error("bus wait not one cycle");
    chk_ca_cause: assert property ($rose(failures_out.carrier_absent_fail) |->
        $past(defects_in.carrier_absent)) else $error("carrier fail without defect");
    chk_fg_block: assert property ($rose(failures_out.framing_gone_fail) |->
        !$past(defects_in.carrier_absent) && !$past(failures_out.carrier_absent_fail))
        else $error("framing fail under carrier loss");
    chk_fg_cleared: assert property ($rose(failures_out.carrier_absent_fail) |->
        ##[0:1] !failures_out.framing_gone_fail) else $error("framing fail kept");
    chk_ca_persist: assert property ($rose(failures_out.carrier_absent_persist) |->
        failures_out.carrier_absent_fail && $past(defects_in.carrier_absent))
        else $error("carrier persist early");
    chk_fg_persist: assert property ($rose(failures_out.framing_gone_persist) |->
        failures_out.framing_gone_fail) else $error("framing persist early");
    chk_leave_data: assert property (state_out == ST_DATA_MODE && !avs_write_in &&
        (failures_out.carrier_absent_persist || failures_out.framing_gone_persist)
        |=> state_out == ST_QUIET_LISTEN) else $error("data mode kept");
    chk_full_reinit: assert property (state_out == ST_DATA_MODE && !avs_write_in &&
        algo_req_in.full_reinit_event |=> state_out == ST_QUIET_LISTEN)
        else $error("full reinit ignored");
    chk_resync_hold: assert property ($rose(state_out == ST_RESYNC) |->
        ##1 (bad_frame_forced_out && tx_on_out)) else $error("resync drops line");
    chk_idle_quiet: assert property ($rose(state_out == ST_IDLE) |->
        ##1 (!tx_on_out && !rx_on_out)) else $error("idle not quiet");
    chk_event_data: assert property ($rose(events_out.resync_needed_event) |->
        $past(state_out == ST_DATA_MODE)) else $error("event outside data");
endmodule

bind line_failure_state_monitor line_monitor_props u_props (.mclk_in, .resetn_in,
    .defects_in, .algo_req_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
    .state_out, .failures_out, .events_out, .bad_frame_forced_out, .tx_on_out, .rx_on_out);

// >>> sim/test_line_failure_state_monitor.sv
// test_line_failure_state_monitor: register, state and failure timing tests.
// assumes TICK_CYCLES of 2, so one ms is two clocks.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// bench
// ---------------------------------------------------------------
module test_line_failure_state_monitor
    import line_fail_pkg::*;
;
    localparam int MS = 2;
    logic clk = 0, resetn = 0, rd = 0, wr = 0, cut = 0, bad = 0, tone;
    logic waitreq, forced, tx_on, rx_on;
    logic [3:0] addr = '0, be = '0;
    logic [31:0] wdata = '0, rdata, q;
    logic [13:0] drv = '0; // request and sequence pulses
    state_t state;
    failure_t fails;
    event_t evts;
    defect_t defs;
    int failures = 0, cmp_count = 0, n;
    state_t tgt [4] = '{ST_RESYNC, ST_RETRAIN, ST_QUIET_LISTEN, ST_INIT_TRAIN};
    logic [13:0] rcv [4] = '{14'h002, 14'h001, 14'h000, 14'h010};

    initial begin
        forever #50 clk = ~clk;
    end

    line_failure_state_monitor #(.TICK_CYCLES(TICK_W'(2))) u_dut (.mclk_in(clk),
        .resetn_in(resetn), .defects_in(defs), .algo_req_in(drv[13:10]),
        .seq_in(drv[9:0] | {2'b0, tone, 7'b0}), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .state_out(state),
        .failures_out(fails), .events_out(evts), .bad_frame_forced_out(forced),
        .tx_on_out(tx_on), .rx_on_out(rx_on));
    line_peer_model u_peer (.mclk_in(clk), .resetn_in(resetn), .state_in(state),
        .cut_in(cut), .bad_in(bad), .defects_out(defs), .tone_out(tone));

    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a spent wait bound ends the run at once
    task bound(input int i, input int lim);
        if (i >= lim) begin
            failures++;
            $display("CHECK FAILED wait expected done seen timeout");
            results();
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk);
        {rd, wr, addr, wdata, be} <= {!w, w, a, d, 4'hf};
        do begin
            @(posedge clk);
            i++;
        end while (waitreq !== 1'b0 && i < 50);
        q = rdata;
        {rd, wr} <= 2'b00;
        bound(i, 50);
    endtask
    task pulse(input logic [13:0] v);
        @(posedge clk);
        drv <= v;
        @(posedge clk);
        drv <= '0;
    endtask
    task wait_st(input state_t s);
        n = 0;
        while (state !== s && n < 30000) begin
            @(posedge clk);
            n++;
        end
        bound(n, 30000);
    endtask
    task wait_fl(input int b, input logic v);
        n = 0;
        while (fails[b] !== v && n < 30000) begin
            @(posedge clk);
            n++;
        end
        bound(n, 30000);
    endtask
    task bring_up();
        wait_st(ST_INIT_HS);
        pulse(14'h020);
        wait_st(ST_INIT_TRAIN);
        pulse(14'h010);
        wait_st(ST_DATA_MODE);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        chk("reset state", 32'(ST_SELFTEST), 32'(state));
        bus(0, REG_CTRL, 0);
        chk("ctrl reset", 32'h7, q);
        bus(0, 4'h2, 0);
        chk("unmapped read", 32'h0, q);
        pulse(14'h200);
        wait_st(ST_IDLE);
        @(posedge clk);
        chk("idle tx rx", 32'h0, 32'({tx_on, rx_on}));
        bus(1, REG_CMD, 32'h2);
        bring_up();
        chk("data tx", 32'h1, 32'(tx_on));
        // every data-mode event, then back to data mode
        for (int i = 0; i < 4; i++) begin
            pulse({4'h8 >> i, 10'h0});
            wait_st(tgt[i]);
            chk("event", 32'(4'h8 >> i), 32'(evts));
            @(posedge clk);
            chk("state", 32'(tgt[i]), 32'(state));
            if (i < 2) chk("forced", 32'h3, 32'({forced, tx_on}));
            if (i == 2) bring_up();
            else begin
                pulse(rcv[i]);
                wait_st(ST_DATA_MODE);
            end
        end
        // carrier loss with bad frames: framing stays blocked
        {cut, bad} <= 2'b11;
        wait_fl(3, 1);
        chk("ca declare", 32'h1, 32'(n >= 2000 * MS && n <= 3000 * MS));
        chk("fg blocked", 32'h0, 32'(fails[2]));
        wait_fl(1, 1);
        chk("ca persist", 32'h1, 32'(n >= 2000 * MS && n <= 3000 * MS));
        repeat (2) @(posedge clk);
        chk("leave data", 32'(ST_QUIET_LISTEN), 32'(state));
        bus(0, REG_STATUS, 0);
        chk("status", 32'h5a, q & 32'h5f);
        {cut, bad} <= 2'b00;
        wait_fl(3, 0);
        chk("ca clear", 32'h1, 32'(n >= 9500 * MS && n <= 10500 * MS));
        bring_up();
        // bad frames alone, then carrier loss over a framing failure
        bad <= 1'b1;
        wait_fl(2, 1);
        chk("fg declare", 32'h1, 32'(n >= 2000 * MS && n <= 3000 * MS));
        wait_fl(0, 1);
        chk("fg persist", 32'h1, 32'(n >= 2000 * MS && n <= 3000 * MS));
        repeat (2) @(posedge clk);
        chk("fg leave", 32'(ST_QUIET_LISTEN), 32'(state));
        cut <= 1'b1;
        wait_fl(3, 1);
        @(posedge clk);
        chk("fg cleared", 32'h0, 32'(fails[2]));
        results();
    end
endmodule
